// [hdl/front_panel_menu_controller.v]
// Purpose: three-key front-panel menu controller with display selection
// Assumes: keys high while pressed, inputs synchronous to mclk_in
// Notes: registers over Avalon-MM, one wait state per access
// Operation
// - parameters unchangeable in display mode
// - parameter key enters programming mode
// - locked access with user input active keeps display mode unless a code is set
// - two modules, prompt alternates with module
// - select steps module, parameter key enters
// - parameter key advances, earlier values kept
// - after last parameter, show exit choice
// - name alternates with value, keys step
// - parameter key stores, activates, advances
// - one flashing digit, rightmost first
// - reset key increments digit, repeats held
// - select key moves digit left
// - exit choice commits memory, returns display
// - secondary display shows designator 2
// - auto scroll toggles displays each interval
// - select key toggles main and secondary
// - reset key resets configured displays
// - module two offers factory defaults
// - reset zeroes main, blanks secondary
// - universal code always grants access
`timescale 1ns/10ps
`include "menu_consts.vh"

module key_debounce #(
  parameter [`DB_W-1:0] CYCLES = 23'h000010
) (
  input wire clk_in,    // system clock
  input wire rst_b_in,  // async reset, low
  input wire raw_in,    // raw key level
  output wire level_out, // debounced level
  output wire press_out  // one-cycle press pulse
);
  reg [`DB_W-1:0] cnt;
  reg level;
  reg press;
  assign level_out = level;
  assign press_out = press;
  // level only follows the key once it stayed put for the full count
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= {`DB_W{1'b0}};
      level <= 1'b0;
      press <= 1'b0;
    end else begin
      press <= 1'b0;
      if (raw_in == level) begin
        cnt <= {`DB_W{1'b0}};
      end else if (cnt >= CYCLES - 23'h000001) begin
        cnt <= {`DB_W{1'b0}};
        level <= raw_in;
        press <= raw_in;
      end else begin
        cnt <= cnt + 23'h000001;
      end
    end
  end
endmodule // key_debounce

module front_panel_menu_controller #(
  parameter [`DB_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_MS * `CLK_KHZ,
  parameter [`TICK_W-1:0] TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
  input wire mclk_in,           // system clock
  input wire rst_b_in,          // async reset, low
  input wire parameter_key_in,  // parameter key, high pressed
  input wire select_key_in,     // select key, high pressed
  input wire reset_key_in,      // reset key, high pressed
  input wire user_input_in,     // user input active, high
  input wire [5:0] address_in,  // avalon byte address
  input wire read_in,           // avalon read
  input wire write_in,          // avalon write
  input wire [31:0] writedata_in, // avalon write data
  output wire [31:0] readdata_out, // avalon read data
  output wire waitrequest_out,  // avalon wait
  output wire prog_mode_out,    // programming mode active
  output wire [1:0] menu_state_out, // menu state
  output wire [1:0] module_out, // module prompt choice
  output wire [3:0] param_index_out, // current parameter
  output wire [15:0] edit_value_out, // value being edited
  output wire [3:0] flash_digit_out, // one-hot flashing digit
  output wire alt_phase_out,    // high shows name, low value
  output wire secondary_shown_out, // secondary display shown
  output wire designator_out,   // show 2 at far right
  output wire [23:0] shown_value_out, // displayed characters
  output wire param_store_out,  // pulse, value stored
  output wire nv_commit_out,    // pulse, commit to memory
  output wire factory_load_out  // pulse, defaults loaded
);
  localparam ST_DISP = `S_DISP, ST_CODE = `S_CODE, ST_MOD = `S_MOD, ST_PARAM = `S_PARAM;

  wire rst_lvl;
  wire par_p, sel_p, rst_p;
  key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_par (.clk_in(mclk_in), .rst_b_in(rst_b_in),
    .raw_in(parameter_key_in), .level_out(), .press_out(par_p));
  key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_sel (.clk_in(mclk_in), .rst_b_in(rst_b_in),
    .raw_in(select_key_in), .level_out(), .press_out(sel_p));
  key_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_rst (.clk_in(mclk_in), .rst_b_in(rst_b_in),
    .raw_in(reset_key_in), .level_out(rst_lvl), .press_out(rst_p));

  reg [15:0] pmem [0:15];
  reg [1:0] state, modsel, digit;
  reg [3:0] pidx;
  reg [15:0] edit;
  reg alt, show_sec, desig;
  reg [23:0] main_val, sec_val, shown;
  reg store_p, commit_p, fact_p;
  reg lock_fn, tick;
  reg [3:0] bus_idx, alt_cnt, rep_cnt;
  reg [`TICK_W-1:0] tick_cnt;
  reg [9:0] scroll_cnt;
  reg wait_r;
  reg [31:0] rdata, next_rdata;
  integer i;

  function [15:0] pdefault;
    input [3:0] idx;
    begin
      case (idx)
        `P_INTENS: pdefault = `DEF_INTENS;
        `P_RST_CFG: pdefault = `DEF_RST_CFG;
        default: pdefault = `DEF_ZERO;
      endcase
    end
  endfunction

  // number of choices in a selection list; numeric ones return zero
  function [15:0] sel_limit;
    input [3:0] idx;
    begin
      case (idx)
        `P_SEC_EN, `P_SEL_EN, `P_FACTORY: sel_limit = 16'h0002;
        `P_RST_CFG: sel_limit = 16'h0005;
        `P_SCROLL, `P_INTENS, `P_CODE: sel_limit = 16'h0000;
        default: sel_limit = `DEF_SEL_LIM;
      endcase
    end
  endfunction

  wire numeric = (sel_limit(pidx) == 16'h0000) || (state == ST_CODE);
  wire [15:0] lim = sel_limit(pidx);
  wire [3:0] cur_nib = edit[{digit, 2'b00} +: 4];
  wire [3:0] inc_nib = (cur_nib >= 4'h9) ? 4'h0 : cur_nib + 4'h1;
  wire [15:0] code = pmem[`P_CODE];
  wire sec_en = (pmem[`P_SEC_EN] != 16'h0000);
  wire [15:0] scr = pmem[`P_SCROLL];
  wire [9:0] scroll_lim = ({6'h00, scr[7:4]} * `TICKS_PER_TEN) + ({6'h00, scr[3:0]} * `TICKS_PER_SEC);
  wire [2:0] rcfg = pmem[`P_RST_CFG][2:0];
  wire [3:0] last_idx = (modsel == `MOD_ONE) ? `M1_LAST : `M2_LAST;
  wire wr = write_in && !wait_r;
  wire repeat_fire = rst_lvl && tick && (rep_cnt >= `REPEAT_TICKS - 4'h1);

  assign readdata_out = rdata;
  assign waitrequest_out = wait_r;
  assign prog_mode_out = (state != ST_DISP);
  assign menu_state_out = state;
  assign module_out = modsel;
  assign param_index_out = pidx;
  assign edit_value_out = edit;
  assign flash_digit_out = {digit == 2'h3, digit == 2'h2, digit == 2'h1, digit == 2'h0};
  assign alt_phase_out = alt;
  assign secondary_shown_out = show_sec;
  assign designator_out = desig;
  assign shown_value_out = shown;
  assign param_store_out = store_p;
  assign nv_commit_out = commit_p;
  assign factory_load_out = fact_p;

  // base tick drives name/value alternation, key repeat and scrolling
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= {`TICK_W{1'b0}};
      tick <= 1'b0;
      alt_cnt <= 4'h0;
      alt <= 1'b1;
      rep_cnt <= 4'h0;
    end else begin
      tick <= (tick_cnt >= TICK_CYCLES - 24'h000001);
      tick_cnt <= (tick_cnt >= TICK_CYCLES - 24'h000001) ? {`TICK_W{1'b0}} : tick_cnt + 24'h000001;
      if (tick) begin
        alt_cnt <= (alt_cnt >= `ALT_TICKS - 4'h1) ? 4'h0 : alt_cnt + 4'h1;
        if (alt_cnt >= `ALT_TICKS - 4'h1) begin
          alt <= !alt;
        end
      end
      if (!rst_lvl) begin
        rep_cnt <= 4'h0;
      end else if (tick) begin
        rep_cnt <= (rep_cnt >= `REPEAT_TICKS - 4'h1) ? 4'h0 : rep_cnt + 4'h1;
      end
    end
  end

  // menu, parameter store and display values share one process
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (i = 0; i < 16; i = i + 1) begin
        pmem[i] <= `DEF_ZERO;
      end
      state <= ST_DISP;
      modsel <= `MOD_ONE;
      pidx <= `M1_FIRST;
      edit <= `DEF_ZERO;
      digit <= 2'h0;
      show_sec <= 1'b0;
      desig <= 1'b0;
      main_val <= `ZERO_DISP;
      sec_val <= `BLANK_DISP;
      shown <= `ZERO_DISP;
      store_p <= 1'b0;
      commit_p <= 1'b0;
      fact_p <= 1'b0;
      lock_fn <= 1'b0;
      bus_idx <= 4'h0;
      scroll_cnt <= 10'h000;
    end else begin
      store_p <= 1'b0;
      commit_p <= 1'b0;
      fact_p <= 1'b0;
      shown <= show_sec ? sec_val : main_val;
      desig <= show_sec;
      if (!sec_en) begin
        show_sec <= 1'b0;
      end
      if (wr) begin
        case (address_in)
          `R_CONTROL: lock_fn <= writedata_in[0];
          `R_PINDEX: bus_idx <= writedata_in[3:0];
          `R_PDATA: begin
            if (state != ST_DISP) begin
              pmem[bus_idx] <= writedata_in[15:0];
            end
          end
          `R_MAIN: main_val <= writedata_in[23:0];
          `R_SEC: sec_val <= writedata_in[23:0];
          default: ;
        endcase
      end
      case (state)
        ST_DISP: begin
          if (sec_en && scroll_lim != 10'h000 && tick) begin
            if (scroll_cnt >= scroll_lim - 10'h001) begin
              scroll_cnt <= 10'h000;
              show_sec <= !show_sec;
            end else begin
              scroll_cnt <= scroll_cnt + 10'h001;
            end
          end
          if (par_p) begin
            edit <= `DEF_ZERO;
            digit <= 2'h0;
            modsel <= `MOD_ONE;
            // with the lock on, inactive user input skips the code check
            if (lock_fn && !user_input_in) begin
              state <= ST_MOD;
            end else if (code == `DEF_ZERO) begin
              state <= lock_fn ? ST_DISP : ST_MOD;
            end else begin
              state <= ST_CODE;
            end
          end else if (sel_p) begin
            if (sec_en && pmem[`P_SEL_EN] != 16'h0000) begin
              show_sec <= !show_sec;
              scroll_cnt <= 10'h000;
            end
          end else if (rst_p) begin
            if (rcfg == `RC_PRI || rcfg == `RC_BOTH || (rcfg == `RC_DSP && !show_sec)) begin
              main_val <= `ZERO_DISP;
            end
            if (sec_en && (rcfg == `RC_SEC || rcfg == `RC_BOTH || (rcfg == `RC_DSP && show_sec))) begin
              sec_val <= `BLANK_DISP;
            end
          end
        end
        ST_MOD: begin
          show_sec <= 1'b0;
          if (sel_p) begin
            modsel <= (modsel == `MOD_EXIT) ? `MOD_ONE : modsel + 2'h1;
          end else if (par_p) begin
            if (modsel == `MOD_EXIT) begin
              commit_p <= 1'b1;
              state <= ST_DISP;
            end else begin
              pidx <= (modsel == `MOD_ONE) ? `M1_FIRST : `P_SEC_EN;
              edit <= pmem[(modsel == `MOD_ONE) ? `M1_FIRST : `P_SEC_EN];
              digit <= 2'h0;
              state <= ST_PARAM;
            end
          end
        end
        ST_CODE, ST_PARAM: begin
          if (par_p) begin
            digit <= 2'h0;
            if (state == ST_CODE) begin
              if (edit == code || edit == `UNIVERSAL_CODE) begin
                state <= ST_MOD;
              end else begin
                state <= ST_DISP;
              end
            end else begin
              pmem[pidx] <= edit;
              store_p <= 1'b1;
              if (pidx == `P_FACTORY && edit != `DEF_ZERO) begin
                for (i = 0; i < 16; i = i + 1) begin
                  pmem[i] <= pdefault(i[3:0]);
                end
                fact_p <= 1'b1;
              end
              if (pidx == last_idx) begin
                modsel <= `MOD_EXIT;
                state <= ST_MOD;
              end else begin
                pidx <= pidx + 4'h1;
                edit <= pmem[pidx + 4'h1];
              end
            end
          end else if (numeric) begin
            if (sel_p) begin
              digit <= digit + 2'h1;
            end else if (rst_p || repeat_fire) begin
              edit[{digit, 2'b00} +: 4] <= inc_nib;
            end
          end else if (sel_p) begin
            edit <= (edit >= lim - 16'h0001) ? `DEF_ZERO : edit + 16'h0001;
          end else if (rst_p) begin
            edit <= (edit == `DEF_ZERO) ? lim - 16'h0001 : edit - 16'h0001;
          end
        end
        default: state <= ST_DISP;
      endcase
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (address_in)
      `R_STATUS: next_rdata = {22'h000000, show_sec, alt, pidx, modsel, state};
      `R_CONTROL: next_rdata = {31'h00000000, lock_fn};
      `R_PINDEX: next_rdata = {28'h0000000, bus_idx};
      `R_PDATA: next_rdata = {16'h0000, pmem[bus_idx]};
      `R_MAIN: next_rdata = {8'h00, main_val};
      `R_SEC: next_rdata = {8'h00, sec_val};
      `R_EDIT: next_rdata = {14'h0000, digit, edit};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // one wait state: data is captured as waitrequest drops
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_r <= 1'b1;
      rdata <= 32'h00000000;
    end else begin
      if ((read_in || write_in) && wait_r) begin
        wait_r <= 1'b0;
        rdata <= read_in ? next_rdata : 32'h00000000;
      end else begin
        wait_r <= 1'b1;
      end
    end
  end
endmodule // front_panel_menu_controller

// [hdl/menu_consts.vh]
// Purpose: constants for the front-panel key and menu controller
// Assumes: 125 MHz system clock
// Notes: four-digit values are held as BCD, one nibble per digit
`ifndef MENU_CONSTS_VH
`define MENU_CONSTS_VH
`define CLK_KHZ 125000
`define DEBOUNCE_MS 20
`define TICK_MS 100
`define DB_W 23
`define TICK_W 24
`define ALT_TICKS 4'h5
`define REPEAT_TICKS 4'h3
`define TICKS_PER_SEC 10'h00A
`define TICKS_PER_TEN 10'h064
// menu states
`define S_DISP 2'h0
`define S_CODE 2'h1
`define S_MOD 2'h2
`define S_PARAM 2'h3
// module prompt choices
`define MOD_ONE 2'h0
`define MOD_TWO 2'h1
`define MOD_EXIT 2'h2
// parameter indices
`define M1_FIRST 4'h0
`define M1_LAST 4'h3
`define P_SEC_EN 4'h4
`define P_SEL_EN 4'h5
`define P_SCROLL 4'h6
`define P_RST_CFG 4'h7
`define P_INTENS 4'h8
`define P_CODE 4'h9
`define P_FACTORY 4'hA
`define M2_LAST 4'hA
// reset assignment choices
`define RC_PRI 3'h1
`define RC_SEC 3'h2
`define RC_BOTH 3'h3
`define RC_DSP 3'h4
// defaults and special values
`define DEF_ZERO 16'h0000
`define DEF_INTENS 16'h0003
`define DEF_RST_CFG 16'h0004
`define DEF_SEL_LIM 16'h0008
`define UNIVERSAL_CODE 16'h0222
`define ZERO_DISP 24'h000000
`define BLANK_DISP 24'hFFFFFF
// register byte offsets
`define R_STATUS 6'h00
`define R_CONTROL 6'h04
`define R_PINDEX 6'h08
`define R_PDATA 6'h0C
`define R_MAIN 6'h10
`define R_SEC 6'h14
`define R_EDIT 6'h18
`endif

// [test/menu_chk.sv]
// Purpose: port-level checks of the front-panel menu controller
// Assumes: one clock, asynchronous active-low reset
// Notes: pulse checks expect each pulse to land with its state change
`timescale 1ns/10ps
`include "menu_consts.vh"
module menu_chk (
  input wire mclk_in, // system clock
  input wire rst_b_in, // async reset, low
  input wire read_in, // avalon read
  input wire write_in, // avalon write
  input wire waitrequest_out, // avalon wait
  input wire prog_mode_out, // programming mode
  input wire [1:0] menu_state_out, // menu state
  input wire [1:0] module_out, // module choice
  input wire [3:0] param_index_out, // parameter index
  input wire [3:0] flash_digit_out, // flashing digit
  input wire secondary_shown_out, // secondary shown
  input wire designator_out, // designator shown
  input wire param_store_out, // store pulse
  input wire nv_commit_out, // commit pulse
  input wire factory_load_out // defaults pulse
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  property p_prog; prog_mode_out == (menu_state_out != `S_DISP); endproperty
  a_prog: assert property (p_prog) else $error("mode flag disagrees with state");
  property p_quiet; menu_state_out == `S_DISP && $past(menu_state_out) == `S_DISP |-> !param_store_out; endproperty
  a_quiet: assert property (p_quiet) else $error("store while in display mode");
  property p_store; param_store_out |-> $past(menu_state_out) == `S_PARAM; endproperty
  a_store: assert property (p_store) else $error("store outside a parameter");
  property p_last; $past(menu_state_out) == `S_PARAM && menu_state_out == `S_MOD |-> module_out == `MOD_EXIT; endproperty
  a_last: assert property (p_last) else $error("exit choice not offered");
  property p_commit; nv_commit_out |-> menu_state_out == `S_DISP && $past(menu_state_out) == `S_MOD; endproperty
  a_commit: assert property (p_commit) else $error("commit without exit");
  property p_factory; factory_load_out |-> $past(param_index_out) == `P_FACTORY; endproperty
  a_factory: assert property (p_factory) else $error("defaults from wrong place");
  property p_flash; $onehot(flash_digit_out); endproperty
  a_flash: assert property (p_flash) else $error("not one flashing digit");
  property p_desig; designator_out == $past(secondary_shown_out); endproperty
  a_desig: assert property (p_desig) else $error("designator wrong");
  property p_mods; module_out != 2'h3; endproperty
  a_mods: assert property (p_mods) else $error("third module offered");
  // one wait state: a slow answer would stall every access
  property p_wait; (read_in || write_in) && waitrequest_out |=> !waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  c_commit: cover property (nv_commit_out);
  c_store: cover property (param_store_out);
  c_sec: cover property (secondary_shown_out);
endmodule // menu_chk
bind front_panel_menu_controller menu_chk i_menu_chk (.mclk_in, .rst_b_in, .read_in, .write_in,
  .waitrequest_out, .prog_mode_out, .menu_state_out, .module_out, .param_index_out, .flash_digit_out,
  .secondary_shown_out, .designator_out, .param_store_out, .nv_commit_out, .factory_load_out);

// [test/key_operator.sv]
// Purpose: operator model pressing the three front-panel keys
// Assumes: keys active high, one key at a time
// Notes: each press opens with a bounce the debouncer must ignore
`timescale 1ns/10ps
module key_operator (
  input wire clk_in, // system clock
  output logic [2:0] key_out // reset, select, parameter
);
  initial key_out = 3'h0;
  // k: 0 parameter, 1 select, 2 reset; n: cycles held
  task automatic press(input int k, input int n);
    @(posedge clk_in) key_out[k] <= 1'b1;
    @(posedge clk_in) key_out[k] <= 1'b0;
    repeat (n) @(posedge clk_in) key_out[k] <= 1'b1;
    @(posedge clk_in) key_out[k] <= 1'b0;
    // release gap longer than the debounce so the next press is seen anew
    repeat (12) @(posedge clk_in);
  endtask
endmodule // key_operator

// [test/front_panel_menu_controller_tb_top.sv]
// Purpose: self-checking bench for the front-panel menu controller
// Assumes: short debounce and tick counts keep key timing brief
// Notes: register reads are scored against a queue of expected words
`timescale 1ns/10ps
`include "menu_consts.vh"
module front_panel_menu_controller_tb_top;
  localparam [31:0] ALL = 32'hFFFFFFFF;
  localparam [31:0] ST = 32'h000002FF;
  localparam [31:0] ED = 32'h0003FFFF;
  logic mclk_in, rst_b_in, user_input_in, read_in, write_in, sv;
  logic [5:0] address_in;
  logic [31:0] writedata_in;
  wire [31:0] readdata_out;
  wire waitrequest_out, secondary_shown_out;
  wire [2:0] keys;
  logic [31:0] exq[$], mq[$];
  logic [15:0] seed = 16'hBACC;
  int bad_count = 0, compares = 0, cycles = 0, i, n;
  front_panel_menu_controller #(.DEBOUNCE_CYCLES(23'h000004), .TICK_CYCLES(24'h000008)) i_front_panel_menu_controller (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .parameter_key_in(keys[0]), .select_key_in(keys[1]),
    .reset_key_in(keys[2]), .user_input_in(user_input_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .prog_mode_out(), .menu_state_out(), .module_out(),
    .param_index_out(), .edit_value_out(), .flash_digit_out(), .alt_phase_out(),
    .secondary_shown_out(secondary_shown_out), .designator_out(), .shown_value_out(),
    .param_store_out(), .nv_commit_out(), .factory_load_out());
  key_operator i_key_operator (.clk_in(mclk_in), .key_out(keys));
  function automatic [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic [31:0] st(input [3:0] x, input [1:0] m, input [1:0] s);
    st = {24'h0, x, m, s};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // request held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    address_in <= a;
    writedata_in <= d;
    write_in <= w;
    read_in <= ~w;
    do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pd(input logic [3:0] x, input logic [31:0] e);
    wr(`R_PINDEX, {28'h0, x});
    rd(`R_PDATA, e, ALL);
  endtask
  task automatic key(input int k);
    i_key_operator.press(k, 10);
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (read_in && waitrequest_out === 1'b0 && exq.size() > 0) chk("readdata", readdata_out & mq.pop_front(), exq.pop_front());
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    rst_b_in = 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 6'h00;
    writedata_in = 32'h0;
    user_input_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    rd(`R_MAIN, {8'h0, `ZERO_DISP}, ALL);
    rd(`R_SEC, {8'h0, `BLANK_DISP}, ALL);
    rd(6'h3C, 32'h0, ALL);
    seed = nxt(seed);
    wr(`R_PINDEX, 32'h8);
    wr(`R_PDATA, {16'h0, seed});
    rd(`R_PDATA, 32'h0, ALL);
    key(0);
    rd(`R_STATUS, st(`M1_FIRST, `MOD_ONE, `S_MOD), ST);
    key(1);
    rd(`R_STATUS, st(`M1_FIRST, `MOD_TWO, `S_MOD), ST);
    key(0);
    rd(`R_STATUS, st(`P_SEC_EN, `MOD_TWO, `S_PARAM), ST);
    key(1);
    rd(`R_EDIT, 32'h1, ED);
    key(0);
    rd(`R_STATUS, st(`P_SEL_EN, `MOD_TWO, `S_PARAM), ST);
    key(1);
    key(0);
    key(0);
    repeat (3) key(1);
    key(2);
    rd(`R_EDIT, 32'h2, ED);
    key(1);
    key(0);
    rd(`R_EDIT, 32'h0, ED);
    key(2);
    key(1);
    key(2);
    rd(`R_EDIT, 32'h10011, ED);
    repeat (3) key(0);
    rd(`R_STATUS, {28'h0, `MOD_EXIT, `S_MOD}, 32'hF);
    key(0);
    rd(`R_STATUS, 32'h0, 32'h3);
    pd(4'h6, 32'h0);
    pd(4'h7, 32'h3);
    pd(4'h8, 32'h11);
    key(1);
    rd(`R_STATUS, 32'h200, 32'h200);
    seed = nxt(seed);
    wr(`R_MAIN, {8'h0, seed, seed[7:0]});
    wr(`R_SEC, {8'h0, seed[7:0], seed});
    key(2);
    rd(`R_MAIN, {8'h0, `ZERO_DISP}, ALL);
    rd(`R_SEC, {8'h0, `BLANK_DISP}, ALL);
    key(1);
    rd(`R_STATUS, 32'h0, 32'h200);
    wr(`R_CONTROL, 32'h1);
    user_input_in <= 1'b1;
    key(0);
    rd(`R_STATUS, 32'h0, 32'h3);
    user_input_in <= 1'b0;
    key(0);
    wr(`R_PINDEX, 32'h9);
    wr(`R_PDATA, 32'h0123);
    wr(`R_PINDEX, 32'h6);
    wr(`R_PDATA, 32'h1);
    key(1);
    key(1);
    key(0);
    repeat (20) @(posedge mclk_in);
    n = 0;
    for (i = 0; i < 160; i++) begin
      sv = secondary_shown_out;
      @(posedge mclk_in);
      if (secondary_shown_out !== sv) n++;
    end
    chk("scroll toggles", n, 32'h2);
    // with the lock function off a nonzero code must be asked for
    wr(`R_CONTROL, 32'h0);
    key(0);
    rd(`R_STATUS, {30'h0, `S_CODE}, 32'h3);
    for (i = 0; i < 3; i++) begin
      key(2);
      key(2);
      key(1);
    end
    key(0);
    rd(`R_STATUS, {30'h0, `S_MOD}, 32'h3);
    key(1);
    repeat (7) key(0);
    key(1);
    key(0);
    pd(4'h8, {16'h0, `DEF_INTENS});
    key(0);
    rd(`R_STATUS, 32'h0, 32'h3);
    report_and_stop;
  end
endmodule // front_panel_menu_controller_tb_top
